// ### logic/jog_home_pkg.sv
// package: constants, enums and carrier structs of the jog and homing sequencer
package jog_home_pkg;

  // homing type codes
  localparam logic [3:0] HT_DOG       = 4'h0;
  localparam logic [3:0] HT_COUNT     = 4'h1;
  localparam logic [3:0] HT_DATA_SET  = 4'h2;
  localparam logic [3:0] HT_STOPPER   = 4'h3;
  localparam logic [3:0] HT_SERVO_ON  = 4'h4;
  localparam logic [3:0] HT_DOG_REAR  = 4'h5;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_JOG      = 8'h04;
  localparam logic [7:0] OFS_RAMP     = 8'h08;
  localparam logic [7:0] OFS_HOME     = 8'h0c;
  localparam logic [7:0] OFS_SHIFT    = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_POS      = 8'h18;
  localparam logic [7:0] OFS_HOMEPOS  = 8'h1c;

  // ctrl and home register fields
  localparam int CTRL_DIR_BIT   = 0;
  localparam int CTRL_HDIR_BIT  = 1;
  localparam int CTRL_ABS_BIT   = 2;
  localparam int HOME_TYPE_LSB  = 0;
  localparam int HOME_DIST_LSB  = 8;

  // reset values, speed step and creep speed
  localparam logic [15:0] JOG_SPEED_RST = 16'h0064;
  localparam logic [15:0] RAMP_RST      = 16'h0010;
  localparam logic [15:0] SPEED_STEP    = 16'h0001;
  localparam logic [15:0] CREEP_SPEED   = 16'h0004;

  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

  typedef enum logic [1:0] {
    MOT_IDLE,
    MOT_RUN,
    MOT_STOP
  } motion_e;

  typedef enum logic [3:0] {
    HS_IDLE,
    HS_BACKOFF,
    HS_SEEK,
    HS_DECEL,
    HS_REAR,
    HS_ZWAIT,
    HS_DIST,
    HS_SHIFT,
    HS_PRESS,
    HS_DONE
  } home_e;

  // fieldbus remote input bits
  typedef struct packed {
    logic       auto_manual_select;
    logic       forward_start;
    logic       reverse_start;
    logic       home_start;
    logic [4:0] table_select_low_bits;
    logic [2:0] table_select_high_bits;
  } remote_in_s;

  // motion command toward the drive core
  typedef struct packed {
    logic        move;
    logic        ccw;
    logic [15:0] speed;
    logic [15:0] ramp;
  } motion_cmd_s;

endpackage : jog_home_pkg

// ### logic/jog_home_seq.sv
// jog and homing sequencer with an ahb-lite register slave
// Notes on behaviour
// - table select bits ignored during jog
// - jog runs at jog speed parameter
// - jog ramps come from table entry one
// - direction parameter swaps forward and reverse
// - forward start runs jog at speed
// - reverse start rotates opposite to forward
// - incremental system loses home at power-on
// - absolute system keeps home once homed
// - start at or past dog backs off first; here only a start with dog high backs off
// - dog type homes on Z after rear
// - count type homes on Z after distance
// - data setting takes current position as home
// - stopper type homes where axis stalls
// - servo-on position becomes home
// - rear reference homes after distance plus shift
// - homing type codes zero through five
// - homing direction parameter sets start direction
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/1ps
module jog_home_seq (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic                      hsel,
  input  wire logic                      hready,
  input  wire logic [31:0]               hwdata,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  input  wire jog_home_pkg::remote_in_s  remote_in,
  input  wire logic                      dog,
  input  wire logic                      zpulse,
  input  wire logic                      stalled,
  input  wire logic                      servo_on,
  input  wire logic                      pos_step,
  output jog_home_pkg::motion_cmd_s      motion_cmd,
  output logic                           home_valid,
  output logic                           homing_busy
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                  wr_pend;
    logic                  rd_pend;
    logic [7:0]            addr;
    logic                  rotation_direction_param;
    logic                  homing_direction_param;
    logic                  abs_system;
    logic [15:0]           jog_speed_param;
    logic [15:0]           ramp;
    logic [3:0]            homing_type_param;
    logic [15:0]           after_dog_dist;
    logic [15:0]           shift_dist;
    logic [31:0]           rdata;
    jog_home_pkg::motion_e mot;
    logic                  mot_ccw;
    logic [15:0]           speed;
    logic [15:0]           ramp_cnt;
    jog_home_pkg::home_e   hs;
    logic                  hdir;
    logic [15:0]           dist_cnt;
    logic                  homed;
    logic                  servo_on_d;
    logic [31:0]           pos;
    logic [31:0]           home_pos;
  } state_s;

  state_s st_reg;
  state_s st_next;

  function automatic logic is_manual(input jog_home_pkg::remote_in_s r);
    is_manual = !r.auto_manual_select;
  endfunction : is_manual

  // dir=0: towards increasing address, taken as ccw here
  function automatic logic dir_to_ccw(input logic up);
    dir_to_ccw = up;
  endfunction : dir_to_ccw

  logic addr_phase;
  logic jog_fwd;
  logic jog_rev;
  logic jog_any;
  logic home_move;
  logic [15:0] home_speed;

  assign addr_phase = hsel && hready &&
                      (htrans == jog_home_pkg::HTRANS_NONSEQ ||
                       htrans == jog_home_pkg::HTRANS_SEQ);
  // table select bits take no part in jog decisions
  assign jog_fwd = is_manual(remote_in) && remote_in.forward_start &&
                   !remote_in.reverse_start && st_reg.hs == jog_home_pkg::HS_IDLE;
  assign jog_rev = is_manual(remote_in) && remote_in.reverse_start &&
                   !remote_in.forward_start && st_reg.hs == jog_home_pkg::HS_IDLE;
  assign jog_any = jog_fwd || jog_rev;
  assign home_move = st_reg.hs inside {jog_home_pkg::HS_BACKOFF, jog_home_pkg::HS_SEEK,
                                       jog_home_pkg::HS_DECEL, jog_home_pkg::HS_REAR,
                                       jog_home_pkg::HS_ZWAIT,
                                       jog_home_pkg::HS_DIST, jog_home_pkg::HS_SHIFT,
                                       jog_home_pkg::HS_PRESS};
  assign home_speed = (st_reg.hs == jog_home_pkg::HS_SEEK ||
                       st_reg.hs == jog_home_pkg::HS_BACKOFF) ?
                      st_reg.jog_speed_param : jog_home_pkg::CREEP_SPEED;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.servo_on_d = servo_on;

    // bus slave: zero wait states
    if (st_reg.wr_pend) begin
      unique case (st_reg.addr)
        jog_home_pkg::OFS_CTRL: begin
          st_next.rotation_direction_param = hwdata[jog_home_pkg::CTRL_DIR_BIT];
          st_next.homing_direction_param   = hwdata[jog_home_pkg::CTRL_HDIR_BIT];
          st_next.abs_system               = hwdata[jog_home_pkg::CTRL_ABS_BIT];
        end
        jog_home_pkg::OFS_JOG:   st_next.jog_speed_param = hwdata[15:0];
        jog_home_pkg::OFS_RAMP:  st_next.ramp = hwdata[15:0];
        jog_home_pkg::OFS_HOME: begin
          st_next.homing_type_param = hwdata[jog_home_pkg::HOME_TYPE_LSB +: 4];
          st_next.after_dog_dist    = hwdata[jog_home_pkg::HOME_DIST_LSB +: 16];
        end
        jog_home_pkg::OFS_SHIFT: st_next.shift_dist = hwdata[15:0];
        default: ;
      endcase
    end
    st_next.wr_pend = addr_phase && hwrite;
    st_next.rd_pend = addr_phase && !hwrite;
    if (addr_phase) begin
      st_next.addr = haddr[7:0];
    end
    if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        jog_home_pkg::OFS_CTRL:    st_next.rdata = {29'h0, st_reg.abs_system,
                                                    st_reg.homing_direction_param,
                                                    st_reg.rotation_direction_param};
        jog_home_pkg::OFS_JOG:     st_next.rdata = {16'h0, st_reg.jog_speed_param};
        jog_home_pkg::OFS_RAMP:    st_next.rdata = {16'h0, st_reg.ramp};
        jog_home_pkg::OFS_HOME:    st_next.rdata = {8'h0, st_reg.after_dog_dist,
                                                    4'h0, st_reg.homing_type_param};
        jog_home_pkg::OFS_SHIFT:   st_next.rdata = {16'h0, st_reg.shift_dist};
        jog_home_pkg::OFS_STATUS:  st_next.rdata = {20'h0, 4'(st_reg.hs), 1'h0,
                                                    2'(st_reg.mot), 4'h0, st_reg.homed};
        jog_home_pkg::OFS_POS:     st_next.rdata = st_reg.pos;
        jog_home_pkg::OFS_HOMEPOS: st_next.rdata = st_reg.home_pos;
        default:                   st_next.rdata = 32'h0;
      endcase
    end

    // position tracking
    if (pos_step && motion_cmd.move) begin
      st_next.pos = motion_cmd.ccw ? st_reg.pos + 32'h1 : st_reg.pos - 32'h1;
    end

    // jog motion
    unique case (st_reg.mot)
      jog_home_pkg::MOT_IDLE: begin
        if (jog_any) begin
          // forward = ccw at dir 0, swapped at dir 1
          st_next.mot     = jog_home_pkg::MOT_RUN;
          st_next.mot_ccw = jog_fwd ^ st_reg.rotation_direction_param;
          st_next.ramp_cnt = st_reg.ramp;
        end
      end
      jog_home_pkg::MOT_RUN: begin
        if (!(st_reg.mot_ccw ^ st_reg.rotation_direction_param ? jog_fwd : jog_rev)) begin
          st_next.mot      = jog_home_pkg::MOT_STOP;
          st_next.ramp_cnt = st_reg.ramp;
        end else if (st_reg.ramp_cnt != 16'h0) begin
          st_next.ramp_cnt = st_reg.ramp_cnt - 16'h1;
        end else if (st_reg.speed < st_reg.jog_speed_param) begin
          st_next.speed    = st_reg.speed + jog_home_pkg::SPEED_STEP;
          st_next.ramp_cnt = st_reg.ramp;
        end else begin
          st_next.speed    = st_reg.jog_speed_param;
        end
      end
      jog_home_pkg::MOT_STOP: begin
        if (st_reg.speed == 16'h0) begin
          st_next.mot = jog_home_pkg::MOT_IDLE;
        end else if (st_reg.ramp_cnt != 16'h0) begin
          st_next.ramp_cnt = st_reg.ramp_cnt - 16'h1;
        end else begin
          st_next.speed    = st_reg.speed - jog_home_pkg::SPEED_STEP;
          st_next.ramp_cnt = st_reg.ramp;
        end
      end
      default: st_next.mot = jog_home_pkg::MOT_IDLE;
    endcase

    // servo-on position as home
    if (servo_on && !st_reg.servo_on_d &&
        st_reg.homing_type_param == jog_home_pkg::HT_SERVO_ON) begin
      st_next.home_pos = st_reg.pos;
      st_next.homed    = 1'b1;
    end

    // homing sequence
    unique case (st_reg.hs)
      jog_home_pkg::HS_IDLE: begin
        if (is_manual(remote_in) && remote_in.home_start && st_reg.mot == jog_home_pkg::MOT_IDLE) begin
          st_next.hdir = dir_to_ccw(!st_reg.homing_direction_param);
          unique case (st_reg.homing_type_param)
            jog_home_pkg::HT_DOG, jog_home_pkg::HT_COUNT, jog_home_pkg::HT_DOG_REAR: begin
              // already on the dog: head away from it from the first cycle
              if (dog) begin
                st_next.hdir = !dir_to_ccw(!st_reg.homing_direction_param);
              end
              st_next.hs = dog ? jog_home_pkg::HS_BACKOFF : jog_home_pkg::HS_SEEK;
            end
            jog_home_pkg::HT_DATA_SET: begin
              st_next.home_pos = st_reg.pos;
              st_next.hs       = jog_home_pkg::HS_DONE;
            end
            jog_home_pkg::HT_STOPPER: st_next.hs = jog_home_pkg::HS_PRESS;
            default: ;
          endcase
        end
      end
      jog_home_pkg::HS_BACKOFF: begin
        st_next.hdir = !dir_to_ccw(!st_reg.homing_direction_param);
        if (!dog) begin
          st_next.hdir = dir_to_ccw(!st_reg.homing_direction_param);
          st_next.hs   = jog_home_pkg::HS_SEEK;
        end
      end
      jog_home_pkg::HS_SEEK: begin
        if (dog) begin
          st_next.hs       = jog_home_pkg::HS_DECEL;
          st_next.dist_cnt = st_reg.after_dog_dist;
        end
      end
      jog_home_pkg::HS_DECEL: begin
        unique case (st_reg.homing_type_param)
          jog_home_pkg::HT_COUNT: st_next.hs = jog_home_pkg::HS_DIST;
          default:                st_next.hs = jog_home_pkg::HS_REAR;
        endcase
      end
      jog_home_pkg::HS_REAR: begin
        if (!dog) begin
          st_next.hs = (st_reg.homing_type_param == jog_home_pkg::HT_DOG_REAR) ?
                       jog_home_pkg::HS_DIST : jog_home_pkg::HS_ZWAIT;
        end
      end
      jog_home_pkg::HS_DIST: begin
        if (pos_step) begin
          st_next.dist_cnt = st_reg.dist_cnt - 16'h1;
        end
        if (st_reg.dist_cnt == 16'h0) begin
          st_next.dist_cnt = st_reg.shift_dist;
          // rear reference skips Z; count waits for the next Z
          st_next.hs = (st_reg.homing_type_param == jog_home_pkg::HT_DOG_REAR) ?
                       jog_home_pkg::HS_SHIFT : jog_home_pkg::HS_ZWAIT;
        end
      end
      jog_home_pkg::HS_ZWAIT: begin
        if (zpulse) begin
          st_next.dist_cnt = st_reg.shift_dist;
          st_next.hs       = jog_home_pkg::HS_SHIFT;
        end
      end
      jog_home_pkg::HS_SHIFT: begin
        if (pos_step && st_reg.dist_cnt != 16'h0) begin
          st_next.dist_cnt = st_reg.dist_cnt - 16'h1;
        end
        if (st_reg.dist_cnt == 16'h0) begin
          st_next.home_pos = st_reg.pos;
          st_next.hs       = jog_home_pkg::HS_DONE;
        end
      end
      jog_home_pkg::HS_PRESS: begin
        if (stalled) begin
          st_next.home_pos = st_reg.pos;
          st_next.hs       = jog_home_pkg::HS_DONE;
        end
      end
      jog_home_pkg::HS_DONE: begin
        st_next.homed = 1'b1;
        if (!remote_in.home_start) begin
          st_next.hs = jog_home_pkg::HS_IDLE;
        end
      end
      default: st_next.hs = jog_home_pkg::HS_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg                 <= '0;
      st_reg.mot             <= jog_home_pkg::MOT_IDLE;
      st_reg.hs              <= jog_home_pkg::HS_IDLE;
      st_reg.jog_speed_param <= jog_home_pkg::JOG_SPEED_RST;
      st_reg.ramp            <= jog_home_pkg::RAMP_RST;
      // absolute system keeps home across reset; incremental clears it
      st_reg.homed           <= st_reg.abs_system && st_reg.homed;
      st_reg.abs_system      <= st_reg.abs_system;
      st_reg.home_pos        <= st_reg.abs_system ? st_reg.home_pos : 32'h0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hrdata           = st_reg.rdata;
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign home_valid       = st_reg.homed;
  assign homing_busy      = st_reg.hs != jog_home_pkg::HS_IDLE;
  assign motion_cmd.move  = (st_reg.mot != jog_home_pkg::MOT_IDLE) || home_move;
  assign motion_cmd.ccw   = home_move ? st_reg.hdir : st_reg.mot_ccw;
  assign motion_cmd.speed = home_move ? home_speed : st_reg.speed;
  assign motion_cmd.ramp  = st_reg.ramp;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_auto_no_jog: assert property (@(posedge clk) disable iff (rst)
    remote_in.auto_manual_select && st_reg.mot == jog_home_pkg::MOT_IDLE
      |=> st_reg.mot == jog_home_pkg::MOT_IDLE)
    else $error("jog started in automatic mode");
  a_fwd_dir_map: assert property (@(posedge clk) disable iff (rst)
    st_reg.mot == jog_home_pkg::MOT_IDLE && jog_fwd
      |=> st_reg.mot_ccw == !$past(st_reg.rotation_direction_param))
    else $error("forward direction mapping wrong");
  a_rev_dir_map: assert property (@(posedge clk) disable iff (rst)
    st_reg.mot == jog_home_pkg::MOT_IDLE && jog_rev
      |=> st_reg.mot_ccw == $past(st_reg.rotation_direction_param))
    else $error("reverse direction mapping wrong");
  a_speed_cap: assert property (@(posedge clk) disable iff (rst)
    st_reg.mot == jog_home_pkg::MOT_RUN && $stable(st_reg.jog_speed_param)
      && st_reg.speed <= st_reg.jog_speed_param
      |=> st_reg.speed <= st_reg.jog_speed_param)
    else $error("jog speed exceeds parameter");
  a_release_stop: assert property (@(posedge clk) disable iff (rst)
    st_reg.mot == jog_home_pkg::MOT_RUN && !jog_any
      |=> st_reg.mot == jog_home_pkg::MOT_STOP)
    else $error("release did not decelerate");
  a_ramp_src: assert property (@(posedge clk) disable iff (rst)
    st_reg.mot == jog_home_pkg::MOT_IDLE && jog_any
      |=> st_reg.ramp_cnt == $past(st_reg.ramp) && motion_cmd.ramp == st_reg.ramp)
    else $error("ramp not from table entry one");
  a_dog_backoff: assert property (@(posedge clk) disable iff (rst)
    st_reg.hs == jog_home_pkg::HS_BACKOFF
      |-> motion_cmd.ccw == st_reg.homing_direction_param)
    else $error("backoff not reversed");
  a_data_set: assert property (@(posedge clk) disable iff (rst)
    st_reg.hs == jog_home_pkg::HS_IDLE && is_manual(remote_in) && remote_in.home_start
      && st_reg.mot == jog_home_pkg::MOT_IDLE
      && st_reg.homing_type_param == jog_home_pkg::HT_DATA_SET
      |=> st_reg.hs == jog_home_pkg::HS_DONE && st_reg.home_pos == $past(st_reg.pos))
    else $error("data setting home not taken");
  a_stopper: assert property (@(posedge clk) disable iff (rst)
    st_reg.hs == jog_home_pkg::HS_PRESS && stalled
      |=> st_reg.hs == jog_home_pkg::HS_DONE ##1 st_reg.homed)
    else $error("stopper home not taken");

endmodule : jog_home_seq

// ### test/fieldbus_master_model.sv
// partner model: fieldbus master that drives the remote input bits
`timescale 1ns/1ps
module fieldbus_master_model (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire jog_home_pkg::remote_in_s cmd,
  output jog_home_pkg::remote_in_s      remote_in
);
  logic [7:0] churn_reg;
  // ----------------------------------------
  // remote bits leave on the link one cycle after request
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      churn_reg <= 8'h00;
    end else begin
      churn_reg <= churn_reg + 8'h01;
    end
    remote_in.auto_manual_select     <= cmd.auto_manual_select;
    remote_in.forward_start          <= cmd.forward_start;
    remote_in.reverse_start          <= cmd.reverse_start;
    remote_in.home_start             <= cmd.home_start;
    // low selection bits churn every cycle, high bits every 32 cycles: the block must not look at them
    remote_in.table_select_low_bits  <= churn_reg[4:0];
    remote_in.table_select_high_bits <= churn_reg[7:5];
  end
endmodule : fieldbus_master_model

// ### test/jog_home_seq_tb.sv
// testbench of the jog and homing sequencer
`timescale 1ns/1ps
module jog_home_seq_tb;
  logic        clk, rst, hwrite, hsel, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        dog, zpulse, stalled, servo_on, pos_step, home_valid, homing_busy;
  jog_home_pkg::remote_in_s  cmd, remote_in;
  jog_home_pkg::motion_cmd_s motion_cmd;
  int          num_errors, total_checks;

  assign hready = hreadyout;
  fieldbus_master_model fieldbus_master_model_inst (.clk(clk), .rst(rst), .cmd(cmd),
    .remote_in(remote_in));
  jog_home_seq jog_home_seq_inst (.clk(clk), .rst(rst), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hsel(hsel), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .remote_in(remote_in),
    .dog(dog), .zpulse(zpulse), .stalled(stalled), .servo_on(servo_on),
    .pos_step(pos_step), .motion_cmd(motion_cmd), .home_valid(home_valid),
    .homing_busy(homing_busy));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task close_out;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // wait for a condition on the ready line under a bound
  task wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      $display("ERROR bus ready expected 1 seen %b", hreadyout);
      close_out();
    end
  endtask : wait_ready

  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    haddr  <= {24'h000000, a};
    htrans <= jog_home_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= 3'h2;
    hsel   <= 1'b1;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : ahb

  // 0: move high, 1: move low, 2: speed at jog value, 3: home known
  task wait_for(input int what, input int bound);
    int n;
    for (n = 0; n < bound; n++) begin
      @(posedge clk);
      if ((what == 0 && motion_cmd.move === 1'b1) || (what == 1 && motion_cmd.move === 1'b0)
          || (what == 2 && motion_cmd.speed === 16'h0005) || (what == 3 && home_valid === 1'b1))
        break;
    end
    if (n >= bound) begin
      num_errors++;
      $display("ERROR wait %0d expected 1 seen 0", what);
      close_out();
    end
  endtask : wait_for

  task do_reset(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask : do_reset

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    ahb(1'b0, jog_home_pkg::OFS_JOG, 32'h0);
    check("jog speed reset", {16'h0000, jog_home_pkg::JOG_SPEED_RST}, rd);
    ahb(1'b0, jog_home_pkg::OFS_RAMP, 32'h0);
    check("ramp reset", {16'h0000, jog_home_pkg::RAMP_RST}, rd);
    ahb(1'b1, 8'h40, 32'h0000_00ff);
    ahb(1'b0, 8'h40, 32'h0);
    check("unmapped read", 32'h0000_0000, rd);
    check("hresp", 32'h0, {31'h0, hresp});
    $display("test regs done");
  endtask : t_regs

  task t_jog(input logic fwd, input logic dir);
    ahb(1'b1, jog_home_pkg::OFS_CTRL, {31'h0, dir});
    ahb(1'b1, jog_home_pkg::OFS_JOG, 32'h0000_0005);
    ahb(1'b1, jog_home_pkg::OFS_RAMP, 32'h0000_0002);
    cmd.forward_start <= fwd;
    cmd.reverse_start <= ~fwd;
    wait_for(0, 20);
    check("rotation ccw", {31'h0, fwd ^ dir}, {31'h0, motion_cmd.ccw});
    wait_for(2, 200);
    check("ramp", 32'h0000_0002, {16'h0, motion_cmd.ramp});
    cmd.forward_start <= 1'b0;
    cmd.reverse_start <= 1'b0;
    wait_for(1, 200);
    check("speed after stop", 32'h0, {16'h0, motion_cmd.speed});
    $display("test jog fwd %0d dir %0d done", fwd, dir);
  endtask : t_jog

  task t_both;
    cmd.forward_start <= 1'b1;
    wait_for(2, 200);
    cmd.reverse_start <= 1'b1;
    wait_for(1, 200);
    check("both starts speed", 32'h0, {16'h0, motion_cmd.speed});
    cmd.forward_start <= 1'b0;
    cmd.reverse_start <= 1'b0;
    $display("test both starts done");
  endtask : t_both

  task t_auto;
    cmd.auto_manual_select <= 1'b1;
    cmd.forward_start      <= 1'b1;
    repeat (20) @(posedge clk);
    check("move in auto", 32'h0, {31'h0, motion_cmd.move});
    cmd.forward_start      <= 1'b0;
    cmd.auto_manual_select <= 1'b0;
    $display("test auto done");
  endtask : t_auto

  task t_home(input logic [3:0] kind);
    logic [31:0] p;
    do_reset(2);
    check("home lost", 32'h0, {31'h0, home_valid});
    ahb(1'b1, jog_home_pkg::OFS_HOME, {28'h0, kind});
    // short jog so that the axis is away from zero before homing
    pos_step          <= 1'b1;
    cmd.forward_start <= 1'b1;
    wait_for(0, 20);
    cmd.forward_start <= 1'b0;
    wait_for(1, 50);
    pos_step          <= 1'b0;
    cmd.home_start <= 1'b1;
    stalled        <= 1'b1;
    repeat (4) @(posedge clk);
    servo_on       <= 1'b1;
    wait_for(3, 100);
    cmd.home_start <= 1'b0;
    stalled        <= 1'b0;
    servo_on       <= 1'b0;
    ahb(1'b0, jog_home_pkg::OFS_POS, 32'h0);
    p = rd;
    ahb(1'b0, jog_home_pkg::OFS_HOMEPOS, 32'h0);
    check("home pos", p, rd);
    $display("test home type %0d done", kind);
  endtask : t_home

  task t_abs;
    ahb(1'b1, jog_home_pkg::OFS_CTRL, 32'h0000_0004);
    do_reset(2);
    check("home kept", 32'h1, {31'h0, home_valid});
    ahb(1'b1, jog_home_pkg::OFS_CTRL, 32'h0000_0000);
    do_reset(2);
    check("home cleared", 32'h0, {31'h0, home_valid});
    $display("test absolute done");
  endtask : t_abs

  // axis model: dog covers positions 10 to 19, a Z mark every 8 units
  task t_dog(input logic [3:0] kind, input int start, input int min_home);
    int   p, n;
    logic first;
    do_reset(2);
    ahb(1'b1, jog_home_pkg::OFS_HOME, {8'h00, 16'h0003, 4'h0, kind});
    ahb(1'b1, jog_home_pkg::OFS_SHIFT, 32'h0000_0002);
    p     = start;
    first = 1'b1;
    dog            <= (p >= 10 && p < 20);
    pos_step       <= 1'b1;
    cmd.home_start <= 1'b1;
    for (n = 0; n < 400 && home_valid !== 1'b1; n++) begin
      @(posedge clk);
      if (motion_cmd.move === 1'b1) begin
        if (first) begin
          check("home start dir", {31'h0, (start < 10)}, {31'h0, motion_cmd.ccw});
          first = 1'b0;
        end
        p = motion_cmd.ccw ? p + 1 : p - 1;
      end
      dog    <= (p >= 10 && p < 20);
      zpulse <= (p % 8 == 0);
    end
    if (home_valid !== 1'b1) begin
      num_errors++;
      $display("ERROR home type %0d expected 1 seen 0", kind);
      close_out();
    end
    cmd.home_start <= 1'b0;
    pos_step       <= 1'b0;
    dog            <= 1'b0;
    zpulse         <= 1'b0;
    ahb(1'b0, jog_home_pkg::OFS_HOMEPOS, 32'h0);
    total_checks++;
    if ($signed(rd) < min_home - start) begin
      num_errors++;
      $display("ERROR home pos expected at least %0d seen %0d", min_home - start, $signed(rd));
    end
    $display("test dog home type %0d done", kind);
  endtask : t_dog

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hsel = 1'b0;
    hwdata = 32'h0; dog = 1'b0; zpulse = 1'b0; stalled = 1'b0; servo_on = 1'b0;
    pos_step = 1'b0; cmd = '0; num_errors = 0; total_checks = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_jog(1'b1, 1'b0);
    t_jog(1'b0, 1'b0);
    t_jog(1'b1, 1'b1);
    t_jog(1'b0, 1'b1);
    t_both();
    t_auto();
    t_home(jog_home_pkg::HT_DATA_SET);
    t_home(jog_home_pkg::HT_STOPPER);
    t_home(jog_home_pkg::HT_SERVO_ON);
    t_abs();
    t_dog(jog_home_pkg::HT_DOG_REAR, 15, 25);
    t_dog(jog_home_pkg::HT_DOG, 0, 26);
    t_dog(jog_home_pkg::HT_COUNT, 0, 18);
    close_out();
  end
endmodule : jog_home_seq_tb
